// ---- bench/sac_comp_model.sv ----
// Comparator and capacitor array model facing the trial pattern
`timescale 1ns/1ps
module sac_comp_model (
    input wire logic core_clk,
    input wire logic [sac_pkg::RES_BITS-1:0] trialBits,
    input wire logic [sac_pkg::RES_BITS-1:0] vinCode,
    output logic comparatorOut
);
    import sac_pkg::*;
    // ======================================================================
    // Registered so the answer settles well before the next step tick
    initial comparatorOut = 1'b0;
    always @(posedge core_clk) begin
        comparatorOut <= (trialBits <= vinCode);
    end
endmodule

// ---- bench/sac_conv_ctrl_checker.sv ----
// Concurrent checks on the converter pin behaviour
`timescale 1ns/1ps
module sac_conv_ctrl_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic readConvert,
    input wire logic deviceSelectN,
    input wire logic highByteSelect,
    input wire logic busyN,
    input wire logic [sac_pkg::RES_BITS-1:0] dataOut,
    input wire logic dataOe,
    input wire logic msbSampleSwitch,
    input wire logic offsetSwitchA,
    input wire logic offsetSwitchB,
    input wire logic comparatorAutozeroSwitch,
    input wire logic [sac_pkg::RES_BITS-1:0] trialBits
);
    import sac_pkg::*;
    localparam int CONV_LEN = CONV_STEPS * STEP_CYC;
    logic [7:0] lowCnt_q;
    // ======================================================================
    // Busy low length, counted since repetition cannot reach it
    always_ff @(posedge core_clk) begin
        if (sys_rst || busyN) begin
            lowCnt_q <= 8'h00;
        end else begin
            lowCnt_q <= lowCnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // ======================================================================
    // Assertions
    a_oe_when_idle: assert property (dataOe |-> busyN) else $error("outputs driven while busy");
    a_conv_length: assert property ($rose(busyN) |-> lowCnt_q == CONV_LEN)
        else $error("conversion length wrong");
    a_start_gated: assert property ($fell(busyN) |-> !$past(deviceSelectN, 3) && !$past(highByteSelect, 3))
        else $error("start with select or high byte set");
    a_switch_open: assert property ($fell(busyN) |-> !msbSampleSwitch && !offsetSwitchA && !offsetSwitchB
        && !comparatorAutozeroSwitch && trialBits == 12'h800) else $error("switches not opened at start");
    a_track_early: assert property ($rose(busyN) |-> $past(msbSampleSwitch, 4))
        else $error("tracking not resumed before busy release");
    a_idle_tracks: assert property (busyN |-> msbSampleSwitch && comparatorAutozeroSwitch)
        else $error("not tracking while idle");
    a_hi_byte_lanes: assert property (dataOe && highByteSelect && $past(highByteSelect, 4)
        |-> dataOut[7:4] == 4'h0 && dataOut[3:0] == dataOut[11:8]) else $error("high byte lanes wrong");
    a_desel_float: assert property (deviceSelectN [*5] |-> !dataOe) else $error("driven while deselected");
    a_strobe_float: assert property (!readConvert [*5] |-> !dataOe) else $error("driven with strobe low");
    c_start: cover property ($fell(busyN));
    c_read_full: cover property (dataOe && !highByteSelect);
    c_read_high: cover property (dataOe && highByteSelect);
endmodule
bind sac_conv_ctrl sac_conv_ctrl_checker chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .readConvert(readConvert), .deviceSelectN(deviceSelectN),
    .highByteSelect(highByteSelect), .busyN(busyN), .dataOut(dataOut), .dataOe(dataOe),
    .msbSampleSwitch(msbSampleSwitch), .offsetSwitchA(offsetSwitchA), .offsetSwitchB(offsetSwitchB),
    .comparatorAutozeroSwitch(comparatorAutozeroSwitch), .trialBits(trialBits)
);

// ---- bench/sac_conv_ctrl_test.sv ----
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module sac_conv_ctrl_test;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic readConvert = 1'b1;
    logic deviceSelectN = 1'b0;
    logic highByteSelect = 1'b0;
    logic [11:0] vinCode = 12'ha5c;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rdErr, busyN, dataOe, comparatorOut, irq;
    logic [11:0] dataOut, trialBits;
    int badCount = 0;
    int numChecks = 0;
    sac_conv_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .readConvert(readConvert), .deviceSelectN(deviceSelectN),
        .highByteSelect(highByteSelect), .comparatorOut(comparatorOut), .busyN(busyN),
        .dataOut(dataOut), .dataOe(dataOe), .msbSampleSwitch(), .offsetSwitchA(), .offsetSwitchB(),
        .comparatorAutozeroSwitch(), .trialBits(trialBits), .irq(irq));
    sac_comp_model model (.core_clk(core_clk), .trialBits(trialBits), .vinCode(vinCode),
        .comparatorOut(comparatorOut));
    initial forever #12.5 core_clk = ~core_clk;
    // ======================================================================
    // Tasks
    task results();
        $display("checks=%0d bad=%0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task fail();
        badCount++;
        results();
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) fail();
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdCheck(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task waitBusy(input logic v);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge core_clk);
            if (busyN === v) break;
        end
        if (i == 300) fail();
    endtask
    // Toggles the strobe and restores it; low pulses kept at 3 cycles
    task pulse(input int n);
        @(posedge core_clk);
        readConvert <= ~readConvert;
        tick(n);
        readConvert <= ~readConvert;
    endtask
    // ======================================================================
    // Main sequence
    initial begin
        tick(8);
        sys_rst <= 1'b0;
        tick(4);
        check(32'({busyN, dataOe, irq}), 32'h6);
        rdCheck(ADDR_CTRL, CTRL_RESET);
        rdCheck(ADDR_INT_MASK, 32'h0);
        rdCheck(8'h40, 32'h0);
        check(32'(rdErr), 32'h1);
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        pulse(3);
        waitBusy(1'b0);
        waitBusy(1'b1);
        tick(6);
        check(32'(irq), 32'h1);
        check(32'({dataOe, dataOut}), 32'h1a5c);
        rdCheck(ADDR_RESULT, 32'ha5c);
        rdCheck(ADDR_INT_STAT, 32'h1);
        tick(1);
        check(32'(irq), 32'h0);
        highByteSelect <= 1'b1;
        tick(6);
        check(32'(dataOut), 32'ha0a);
        pulse(3);
        tick(20);
        check(32'(busyN), 32'h1);
        highByteSelect <= 1'b0;
        deviceSelectN <= 1'b1;
        tick(6);
        pulse(3);
        tick(10);
        check(32'({busyN, dataOe}), 32'h2);
        deviceSelectN <= 1'b0;
        rdCheck(ADDR_INT_STAT, 32'h0);
        vinCode <= 12'h3c7;
        tick(6);
        pulse(3);
        waitBusy(1'b0);
        pulse(3);
        waitBusy(1'b1);
        rdCheck(ADDR_RESULT, 32'h3c7);
        rdCheck(ADDR_INT_STAT, 32'h3);
        vinCode <= 12'h7f1;
        readConvert <= 1'b0;
        waitBusy(1'b0);
        waitBusy(1'b1);
        tick(6);
        check(32'(dataOe), 32'h0);
        vinCode <= 12'h0e2;
        pulse(6);
        check(32'({dataOe, dataOut}), 32'h17f1);
        tick(6);
        check(32'({busyN, dataOe}), 32'h0);
        waitBusy(1'b1);
        rdCheck(ADDR_RESULT, 32'h0e2);
        rdCheck(ADDR_INT_STAT, 32'h1);
        readConvert <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h80);
        pulse(3);
        tick(10);
        check(32'({busyN, irq}), 32'h2);
        rdCheck(ADDR_INT_STAT, 32'h2);
        rdCheck(ADDR_CONV_CNT, 32'h4);
        apb(1'b1, ADDR_CTRL, CTRL_RESET);
        pulse(3);
        waitBusy(1'b0);
        readConvert <= 1'b0;
        sys_rst <= 1'b1;
        tick(3);
        sys_rst <= 1'b0;
        tick(10);
        check(32'({busyN, dataOe}), 32'h2);
        rdCheck(ADDR_STATUS, 32'h2);
        rdCheck(ADDR_CTRL, CTRL_RESET);
        results();
    end
endmodule

// ---- shared/sac_pkg.sv ----
// Constants, register map and state encoding for the converter control block
// ==========================================================================
// Functional notes
// - Start only on strobe fall with select low, high-byte low, not busy.
// - Busy stays asserted through conversion; released after result reaches output latches.
// - While busy, outputs float and control inputs are ignored.
// - Data outputs enabled only with strobe high, not busy, select low.
// - Select high keeps outputs floating and the block takes no action.
// - High-byte select low gives the full 12-bit word, 8 LSBs on low lanes.
// - High-byte select high puts 4 MSBs on lanes 3..0, lanes 7..4 low.
// - Strobe fall with high-byte select high is a read, never a start.
// - Low-pulse mode: float on strobe fall, drive again after conversion.
// - High-pulse mode: rise drives old result, fall holds input and starts.
// - Tracking resumes when conversion completes, before busy is released.
// - Start opens sample switch, isolates offset switches, releases auto-zero.
// - Bits resolved MSB first; trial bit to reference, lower bits to ground.
// - Conversion at most 2.7 us, so 3 us start spacing is sustained.
package sac_pkg;
    // ======================================================================
    // Resolution and timing
    localparam int RES_BITS = 12;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_MAX_NS = 2700;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_STEPS = RES_BITS + 1;
    localparam int STEP_CYC = CONV_MAX_CYC / CONV_STEPS;
    localparam int TRIM_W = 4;
    localparam int CNT_W = 16;

    // ======================================================================
    // APB register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_CONV_CNT = 8'h14;

    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TRIM_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0081;

    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TRACK_BIT = 1;
    localparam int STAT_OE_BIT = 2;
    localparam int STAT_SEL_BIT = 3;
    localparam int STAT_HBS_BIT = 4;
    localparam int STAT_RC_BIT = 5;

    // Interrupt fields
    localparam int INT_W = 2;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_REJECT_BIT = 1;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;

    // ======================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_TRACK = 3'b001,
        ST_TRIAL = 3'b010,
        ST_LATCH = 3'b100
    } sac_state_t;
endpackage

// ---- src/sac_conv_ctrl.sv ----
// Converter control: pin interface, step timing, APB registers, interrupt
`timescale 1ns/1ps
module sac_conv_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter pins
    input wire logic readConvert,
    input wire logic deviceSelectN,
    input wire logic highByteSelect,
    input wire logic comparatorOut,
    output logic busyN,
    output logic [sac_pkg::RES_BITS-1:0] dataOut,
    output logic dataOe,
    // Capacitor array and comparator switches, interrupt
    output logic msbSampleSwitch,
    output logic offsetSwitchA,
    output logic offsetSwitchB,
    output logic comparatorAutozeroSwitch,
    output logic [sac_pkg::RES_BITS-1:0] trialBits,
    output logic irq
);
    import sac_pkg::*;

    // ======================================================================
    // Address decode and trim clamp helpers
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_RESULT) ||
                   (a == ADDR_INT_STAT) || (a == ADDR_INT_MASK) || (a == ADDR_CONV_CNT);
    endfunction

    function automatic logic [TRIM_W-1:0] clampTrim(input logic [TRIM_W-1:0] t);
        // Longer steps would break the conversion-time ceiling
        if (t == '0) begin
            clampTrim = TRIM_W'(1);
        end else if (t > TRIM_W'(STEP_CYC)) begin
            clampTrim = TRIM_W'(STEP_CYC);
        end else begin
            clampTrim = t;
        end
    endfunction

    // ======================================================================
    // Pin synchronisers
    logic rcS1_q, rcS2_q, rcPrev_q;
    logic selS1_q, selS2_q;
    logic hbsS1_q, hbsS2_q;
    logic cmpS1_q, cmpS2_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rcS1_q <= readConvert;
            rcS2_q <= rcS1_q;
            selS1_q <= 1'b1;
            selS2_q <= 1'b1;
            hbsS1_q <= 1'b0;
            hbsS2_q <= 1'b0;
            cmpS1_q <= 1'b0;
            cmpS2_q <= 1'b0;
        end else begin
            rcS1_q <= readConvert;
            rcS2_q <= rcS1_q;
            selS1_q <= deviceSelectN;
            selS2_q <= selS1_q;
            hbsS1_q <= highByteSelect;
            hbsS2_q <= hbsS1_q;
            cmpS1_q <= comparatorOut;
            cmpS2_q <= cmpS1_q;
        end
    end

    // Edge history keeps running while busy, so no edge is remembered
    // Strobe chain follows the pin through reset: a low idle strobe gives no false start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rcPrev_q <= rcS2_q;
        end else begin
            rcPrev_q <= rcS2_q;
        end
    end

    // ======================================================================
    // Control register
    logic [31:0] ctrl_q;
    logic convEnable;
    logic [TRIM_W-1:0] stepLen;

    assign convEnable = ctrl_q[CTRL_EN_BIT];
    assign stepLen = clampTrim(ctrl_q[CTRL_TRIM_LSB +: TRIM_W]);

    // ======================================================================
    // Start decode
    logic rcFall, startConv, rejectConv;
    logic busy, track, convDone;
    logic [RES_BITS-1:0] result;

    // Strobe low for one sample (25 ns) is enough for the fall to be seen
    assign rcFall = rcPrev_q && !rcS2_q;
    // Select high or high-byte high blocks the start
    assign startConv = rcFall && !selS2_q && !hbsS2_q && !busy && convEnable;
    // A start attempt during conversion is dropped
    assign rejectConv = rcFall && !selS2_q && !hbsS2_q && (busy || !convEnable);

    // ======================================================================
    // Step divider restarts with each conversion
    logic [TRIM_W-1:0] stepCnt_q;
    logic stepTick;

    assign stepTick = busy && (stepCnt_q == stepLen - 1'b1);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stepCnt_q <= '0;
        end else if (startConv || stepTick || !busy) begin
            stepCnt_q <= '0;
        end else begin
            stepCnt_q <= stepCnt_q + 1'b1;
        end
    end

    sac_sar_engine #(
        .WIDTH(RES_BITS)
    ) u_sar (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(startConv),
        .stepTick(stepTick),
        .compHigh(cmpS2_q),
        .busy(busy),
        .track(track),
        .done(convDone),
        .trial(trialBits),
        .result(result),
        .msbSampleSwitch(msbSampleSwitch),
        .offsetSwitchA(offsetSwitchA),
        .offsetSwitchB(offsetSwitchB),
        .comparatorAutozeroSwitch(comparatorAutozeroSwitch)
    );

    assign busyN = !busy;

    // ======================================================================
    // Three-state data outputs
    logic dataOe_q;
    logic [RES_BITS-1:0] dataOut_q;
    logic readWindow;

    // Strobe high, idle and selected; start fall floats at once
    assign readWindow = rcS2_q && !busy && !selS2_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dataOe_q <= 1'b0;
        end else begin
            dataOe_q <= readWindow && !startConv;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dataOut_q <= '0;
        end else if (hbsS2_q) begin
            dataOut_q <= {result[11:8], 4'h0, result[11:8]};
        end else begin
            dataOut_q <= result;
        end
    end

    assign dataOe = dataOe_q;
    assign dataOut = dataOut_q;

    // ======================================================================
    // Conversion counter
    logic [CNT_W-1:0] convCnt_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            convCnt_q <= '0;
        end else if (convDone) begin
            convCnt_q <= convCnt_q + 1'b1;
        end
    end

    // ======================================================================
    // APB slave: read data captured in setup, one access cycle
    logic setupPhase, accessPhase, wrAccess, rdAccess;
    logic [31:0] prdata_q;
    logic [31:0] statusWord;
    logic [INT_W-1:0] intStat_q, intMask_q, intEvents, intClear;

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess = accessPhase && pwrite && isMapped(paddr);
    assign rdAccess = accessPhase && !pwrite;
    assign pready = accessPhase;
    assign pslverr = accessPhase && !isMapped(paddr);
    assign prdata = prdata_q;

    always_comb begin
        statusWord = '0;
        statusWord[STAT_BUSY_BIT] = busy;
        statusWord[STAT_TRACK_BIT] = track;
        statusWord[STAT_OE_BIT] = dataOe_q;
        statusWord[STAT_SEL_BIT] = selS2_q;
        statusWord[STAT_HBS_BIT] = hbsS2_q;
        statusWord[STAT_RC_BIT] = rcS2_q;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata_q <= '0;
        end else if (setupPhase && !pwrite) begin
            unique case (1'b1)
                paddr == ADDR_CTRL: prdata_q <= ctrl_q;
                paddr == ADDR_STATUS: prdata_q <= statusWord;
                paddr == ADDR_RESULT: prdata_q <= 32'(result);
                paddr == ADDR_INT_STAT: prdata_q <= 32'(intStat_q);
                paddr == ADDR_INT_MASK: prdata_q <= 32'(intMask_q);
                paddr == ADDR_CONV_CNT: prdata_q <= 32'(convCnt_q);
                default: prdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wrAccess && paddr == ADDR_CTRL) begin
            ctrl_q <= pwdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            intMask_q <= INT_MASK_RESET;
        end else if (wrAccess && paddr == ADDR_INT_MASK) begin
            intMask_q <= pwdata[INT_W-1:0];
        end
    end

    // ======================================================================
    // Interrupts: read clears only what was returned, new events win
    always_comb begin
        intEvents = '0;
        intEvents[INT_DONE_BIT] = convDone;
        intEvents[INT_REJECT_BIT] = rejectConv;
        intClear = '0;
        if (rdAccess && paddr == ADDR_INT_STAT) begin
            intClear = prdata_q[INT_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            intStat_q <= '0;
        end else begin
            intStat_q <= (intStat_q & ~intClear) | intEvents;
        end
    end

    assign irq = |(intStat_q & intMask_q);
endmodule

// ---- src/sac_sar_engine.sv ----
// Successive-approximation sequencer with switch control and output latch
`timescale 1ns/1ps
module sac_sar_engine #(
    parameter int WIDTH = sac_pkg::RES_BITS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic stepTick,
    input wire logic compHigh,
    output logic busy,
    output logic track,
    output logic done,
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] result,
    output logic msbSampleSwitch,
    output logic offsetSwitchA,
    output logic offsetSwitchB,
    output logic comparatorAutozeroSwitch
);
    import sac_pkg::*;

    localparam int IDX_W = $clog2(WIDTH);
    localparam logic [IDX_W-1:0] TOP_IDX = IDX_W'(WIDTH - 1);

    sac_state_t state_q;
    logic [IDX_W-1:0] bitIdx_q;
    logic [WIDTH-1:0] trial_q;
    logic [WIDTH-1:0] result_q;

    // ======================================================================
    // Sequence
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= ST_TRACK;
        end else begin
            unique case (state_q)
                ST_TRACK: if (start) state_q <= ST_TRIAL;
                ST_TRIAL: if (stepTick && bitIdx_q == '0) state_q <= ST_LATCH;
                ST_LATCH: if (stepTick) state_q <= ST_TRACK;
                default: state_q <= ST_TRACK;
            endcase
        end
    end

    // ======================================================================
    // Trial register, MSB first
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bitIdx_q <= TOP_IDX;
            trial_q <= '0;
        end else if (state_q == ST_TRACK && start) begin
            bitIdx_q <= TOP_IDX;
            trial_q <= '0;
            trial_q[WIDTH-1] <= 1'b1;
        end else if (state_q == ST_TRIAL && stepTick) begin
            trial_q[bitIdx_q] <= compHigh;
            if (bitIdx_q != '0) begin
                trial_q[bitIdx_q - 1'b1] <= 1'b1;
                bitIdx_q <= bitIdx_q - 1'b1;
            end
        end
    end

    // Output latch loads one step before busy is released
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_q <= '0;
        end else if (state_q == ST_TRIAL && stepTick && bitIdx_q == '0) begin
            result_q <= {trial_q[WIDTH-1:1], compHigh};
        end
    end

    // ======================================================================
    // Switches close for sampling, also during the latch step
    assign track = (state_q != ST_TRIAL);
    assign msbSampleSwitch = track;
    assign offsetSwitchA = track;
    assign offsetSwitchB = track;
    assign comparatorAutozeroSwitch = track;
    assign busy = (state_q != ST_TRACK);
    assign done = (state_q == ST_LATCH) && stepTick;
    assign trial = trial_q;
    assign result = result_q;
endmodule
